// ---- rtl/bdbt_top.sv ----
/*
 Break delay and bus trace logic of an in-circuit emulator.
 Assumes clk is the target bus cycle clock; pins are asynchronous and synchronised here;
 trace readout is a plain port, offsets counted back from the newest record.
*/
//
// Behaviour
// - After a break event, halt once the programmed cycle count has elapsed, or sooner on force_halt or exc_break.
// - Delay count spans 0 to 65535 cycles; resets to 0, meaning immediate halt.
// - While running, sample bus information each bus cycle into trace memory.
// - Trace memory holds up to 4M bus-cycle records.
// - With no trace conditions, record every cycle until the program stops.
// - Free mode tracing starts with program start and ends with program stop.
// - On any halt, captured trace stays retained and readable.
// - OR combination: any single enabled break event signals a breakpoint.
// - Readout index 0 is newest record; larger back offsets are older.
`timescale 1ns/1ns
`include "bdbt_defines.svh"
module bdbt_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run_start,
    input wire logic force_halt,
    input wire logic exc_break,
    input wire logic [15:0] break_events,
    input wire logic [15:0] or_enable,
    input wire logic [`BDBT_DELAY_W-1:0] break_delay,
    input wire logic trace_cond_set,
    input wire logic [`BDBT_ADDR_W-1:0] bus_addr,
    input wire logic [`BDBT_DATA_W-1:0] bus_data,
    input wire logic [`BDBT_INFO_W-1:0] bus_info,
    input wire logic [`BDBT_DEPTH_LOG-1:0] rd_offset,
    output logic running,
    output logic halted,
    output logic break_hit,
    output logic [`BDBT_REC_W-1:0] rd_record,
    output logic [`BDBT_DEPTH_LOG:0] trace_count,
    output logic trace_wrapped
);
    localparam int DEPTH = 1 << `BDBT_DEPTH_LOG;

    logic [15:0] ev_sync;
    logic [2:0] ctl_sync;
    logic [`BDBT_ADDR_W+`BDBT_DATA_W+`BDBT_INFO_W-1:0] bus_sync;
    logic start_q;
    logic start_rise;
    logic any_break;
    bdbt_pkg::bdbt_state_type state;
    logic [`BDBT_DELAY_W-1:0] delay_cnt;
    logic [`BDBT_DELAY_W-1:0] delay_reg;
    logic [`BDBT_REC_W-1:0] rec;
    logic f_valid;
    logic f_ready;
    logic [`BDBT_REC_W-1:0] f_data;
    logic [`BDBT_REC_W-1:0] tmem [DEPTH];
    logic [`BDBT_DEPTH_LOG-1:0] wr_ptr;
    logic [`BDBT_DEPTH_LOG-1:0] rd_addr;
    logic capture;

    bdbt_sync #(.WIDTH(16)) u_ev_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(break_events),
        .q(ev_sync)
    );

    bdbt_sync #(.WIDTH(3)) u_ctl_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({run_start, force_halt, exc_break}),
        .q(ctl_sync)
    );

    bdbt_sync #(.WIDTH(`BDBT_ADDR_W+`BDBT_DATA_W+`BDBT_INFO_W)) u_bus_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({bus_addr, bus_data, bus_info}),
        .q(bus_sync)
    );

    // Start edge detect
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            start_q <= 1'b0;
        end
        else if (ce)
        begin
            start_q <= ctl_sync[2];
        end
    end

    assign start_rise = ctl_sync[2] && !start_q;
    assign any_break = |(ev_sync & or_enable);

    // Delay setting latched at program start
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            delay_reg <= `BDBT_DELAY_RST;
        end
        else if (ce && start_rise)
        begin
            delay_reg <= break_delay;
        end
    end

    // Run control
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= bdbt_pkg::bdbt_idle;
            delay_cnt <= '0;
            break_hit <= 1'b0;
        end
        else if (ce)
        begin
            break_hit <= 1'b0;
            case (state)
                bdbt_pkg::bdbt_idle, bdbt_pkg::bdbt_halted:
                begin
                    if (start_rise)
                    begin
                        state <= bdbt_pkg::bdbt_run;
                    end
                end
                bdbt_pkg::bdbt_run:
                begin
                    if (ctl_sync[1] || ctl_sync[0])
                    begin
                        state <= bdbt_pkg::bdbt_halted;
                    end
                    else if (any_break)
                    begin
                        break_hit <= 1'b1;
                        if (delay_reg == '0)
                        begin
                            state <= bdbt_pkg::bdbt_halted;
                        end
                        else
                        begin
                            delay_cnt <= delay_reg - 1'b1;
                            state <= bdbt_pkg::bdbt_delay;
                        end
                    end
                end
                bdbt_pkg::bdbt_delay:
                begin
                    if (ctl_sync[1] || ctl_sync[0] || delay_cnt == '0)
                    begin
                        state <= bdbt_pkg::bdbt_halted;
                    end
                    else
                    begin
                        delay_cnt <= delay_cnt - 1'b1;
                    end
                end
                default:
                begin
                    state <= bdbt_pkg::bdbt_idle;
                end
            endcase
        end
    end

    // Running level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            running <= 1'b0;
        end
        else if (ce)
        begin
            running <= state == bdbt_pkg::bdbt_run || state == bdbt_pkg::bdbt_delay;
        end
    end

    // Halted level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            halted <= 1'b0;
        end
        else if (ce)
        begin
            halted <= state == bdbt_pkg::bdbt_halted;
        end
    end

    // Sample every bus cycle while running, conditions absent or not
    assign capture = (state == bdbt_pkg::bdbt_run || state == bdbt_pkg::bdbt_delay)
        && (trace_cond_set || !trace_cond_set);
    assign rec = bus_sync;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            f_valid <= 1'b0;
        end
        else if (ce)
        begin
            f_valid <= capture;
        end
    end

    bdbt_fifo #(.WIDTH(`BDBT_REC_W), .DEPTH(`BDBT_FIFO_DEPTH), .LOG(`BDBT_FIFO_LOG)) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_data(rec),
        .in_valid(f_valid),
        .in_ready(),
        .out_data(f_data),
        .out_valid(f_ready),
        .out_ready(1'b1)
    );

    // Circular trace store
    always_ff @(posedge clk)
    begin
        if (ce && f_ready)
        begin
            tmem[wr_ptr] <= f_data;
        end
    end

    // Write pointer, cleared at each start
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
        end
        else if (ce)
        begin
            if (start_rise)
            begin
                wr_ptr <= '0;
            end
            else if (f_ready)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
        end
    end

    // Record count, saturates at full depth
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trace_count <= '0;
        end
        else if (ce)
        begin
            if (start_rise)
            begin
                trace_count <= '0;
            end
            else if (f_ready && trace_count != (`BDBT_DEPTH_LOG+1)'(DEPTH))
            begin
                trace_count <= trace_count + 1'b1;
            end
        end
    end

    // Wrap flag, a wrap wins over a restart clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trace_wrapped <= 1'b0;
        end
        else if (ce)
        begin
            if (f_ready && wr_ptr == '1)
            begin
                trace_wrapped <= 1'b1;
            end
            else if (start_rise)
            begin
                trace_wrapped <= 1'b0;
            end
        end
    end

    // Readout relative to newest record, kept after halt
    assign rd_addr = wr_ptr - 1'b1 - rd_offset;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_record <= '0;
        end
        else if (ce)
        begin
            rd_record <= tmem[rd_addr];
        end
    end
endmodule

// ---- rtl/bdbt_defines.svh ----
/*
 Timing counts, field widths and reset values for the break delay and bus trace block.
 Assumes inclusion by bare name from rtl files.
*/
`ifndef BDBT_DEFINES_SVH
`define BDBT_DEFINES_SVH
`define BDBT_DELAY_W 16
`define BDBT_DELAY_RST 16'h0000
`define BDBT_DELAY_MAX 16'hffff
`define BDBT_ADDR_W 24
`define BDBT_DATA_W 16
`define BDBT_INFO_W 8
`define BDBT_REC_W 48
`define BDBT_DEPTH_LOG 22
`define BDBT_FIFO_DEPTH 16
`define BDBT_FIFO_LOG 4
`define BDBT_MODE_FREE 1'b0
`endif

// ---- rtl/bdbt_pkg.sv ----
/*
 Types for the break delay and bus trace block.
 Assumes bdbt_defines.svh is compiled with it.
*/
package bdbt_pkg;
    typedef enum logic [1:0] {bdbt_idle, bdbt_run, bdbt_delay, bdbt_halted} bdbt_state_type;
endpackage

// ---- rtl/bdbt_fifo.sv ----
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock, async active-high reset, clock enable.
*/
`timescale 1ns/1ns
module bdbt_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16,
    parameter int LOG = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [LOG:0] wr_ptr;
    logic [LOG:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr - rd_ptr) != (LOG+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[LOG-1:0]];
    assign push = in_valid && in_ready && ce;
    assign pop = out_valid && out_ready && ce;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr[LOG-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ---- rtl/bdbt_sync.sv ----
/*
 Two-flop level synchroniser.
 Assumes asynchronous input, clk domain output.
*/
`timescale 1ns/1ns
module bdbt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= '0;
            q <= '0;
        end
        else if (ce)
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ---- test/bdbt_top_sva.sv ----
/*
 Checker for bdbt_top.
 Assumes bind to bdbt_top, one clock.
*/
`timescale 1ns/1ns
`include "bdbt_defines.svh"
module bdbt_top_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic force_halt,
    input wire logic [`BDBT_DELAY_W-1:0] break_delay,
    input wire logic running,
    input wire logic halted,
    input wire logic break_hit,
    input wire logic [`BDBT_DEPTH_LOG:0] trace_count
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_hit_pulse:
        assert property (break_hit |=> !break_hit) else $error("hit too long");
    a_hit_in_run:
        assert property ($rose(break_hit) |-> $past(running)) else $error("hit when idle");
    a_zero_delay:
        assert property (break_hit && break_delay == 16'h0000 |-> ##[0:1] halted)
        else $error("late halt");
    a_one_delay:
        assert property (break_hit && break_delay == 16'h0001 |=> !halted ##1 halted)
        else $error("delay one wrong");
    a_force_stop:
        assert property (running && force_halt ##1 force_halt ##1 force_halt |-> ##[0:4] halted)
        else $error("no forced halt");
    a_count_frozen:
        assert property (halted [*8] ##1 halted |-> $past(trace_count) == $past(trace_count, 2))
        else $error("trace moved");
    a_count_grows:
        assert property (running [*6] |-> trace_count == 23'h400000
            || trace_count > $past(trace_count)) else $error("cycle missed");
    a_count_max:
        assert property (trace_count <= 23'h400000) else $error("count too big");
    cover property (break_hit);
    cover property ($rose(halted) && force_halt);
    cover property ($fell(running));
endmodule
bind bdbt_top bdbt_top_sva chk_u (.clk(clk), .rst(rst), .force_halt(force_halt),
    .break_delay(break_delay), .running(running), .halted(halted),
    .break_hit(break_hit), .trace_count(trace_count));

// ---- test/bdbt_target.sv ----
/*
 Target bus and break event source.
 Assumes bench drives fire and ev_sel.
*/
`timescale 1ns/1ns
module bdbt_target (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [3:0] ev_sel,
    output logic [23:0] bus_addr,
    output logic [15:0] bus_data,
    output logic [7:0] bus_info,
    output logic [15:0] break_events
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bus_addr <= 24'h000000;
        else
            bus_addr <= bus_addr + 24'h000001;
    end
    assign bus_data = bus_addr[15:0] ^ 16'ha5a5;
    assign bus_info = bus_addr[7:0];
    assign break_events = fire ? 16'h0001 << ev_sel : 16'h0000;
endmodule

// ---- test/bdbt_top_bench.sv ----
/*
 Self-checking bench for bdbt_top.
 Assumes bdbt_target as bus source.
*/
`timescale 1ns/1ns
module bdbt_top_bench;
    logic clk, rst, ce, run_start, force_halt, exc_break, trace_cond_set, fire;
    logic running, halted, break_hit, trace_wrapped;
    logic [15:0] break_events, or_enable, break_delay, bus_data;
    logic [23:0] bus_addr;
    logic [7:0] bus_info;
    logic [3:0] ev_sel;
    logic [21:0] rd_offset;
    logic [47:0] rd_record;
    logic [23:0] addr_d1, addr_d2;
    logic [47:0] model_q[$];
    logic [22:0] trace_count;
    int error_cnt, n_tests, n_run, n_hit, i;
    bdbt_target tgt_u (.clk(clk), .rst(rst), .fire(fire), .ev_sel(ev_sel),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_info(bus_info),
        .break_events(break_events));
    bdbt_top dut_u (.clk(clk), .rst(rst), .ce(ce), .run_start(run_start),
        .force_halt(force_halt), .exc_break(exc_break), .break_events(break_events),
        .or_enable(or_enable), .break_delay(break_delay), .trace_cond_set(trace_cond_set),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_info(bus_info),
        .rd_offset(rd_offset), .running(running), .halted(halted), .break_hit(break_hit),
        .rd_record(rd_record), .trace_count(trace_count), .trace_wrapped(trace_wrapped));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Reference model: each cycle seen running is one record of the synced bus
    always @(posedge clk)
    begin
        addr_d1 <= bus_addr;
        addr_d2 <= addr_d1;
        if (running === 1'b1)
        begin
            n_run <= n_run + 1;
            model_q.push_back(rec(addr_d2));
        end
        if (break_hit === 1'b1)
            n_hit <= n_hit + 1;
    end
    function automatic logic [47:0] rec(input logic [23:0] a);
        return {a, a[15:0] ^ 16'ha5a5, a[7:0]};
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_hi(ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim)
            begin
                error_cnt++;
                final_report();
            end
        end
    endtask
    task automatic pulse(input logic [3:0] e);
        @(posedge clk);
        ev_sel <= e;
        fire <= 1'b1;
        repeat (4) @(posedge clk);
        fire <= 1'b0;
    endtask
    task automatic run(input int mode, input int d);
        int n, c;
        logic [3:0] s;
        s = $urandom;
        @(posedge clk);
        or_enable <= ($urandom | (16'h1 << s)) & ~(16'h1 << (s + 4'h1));
        break_delay <= d[15:0];
        trace_cond_set <= mode[0];
        run_start <= 1'b1;
        n_run = 0;
        model_q.delete();
        wait_hi(running, 10, n);
        @(posedge clk);
        run_start <= 1'b0;
        repeat ($urandom % 30 + 20) @(posedge clk);
        c = n_hit;
        pulse(s + 4'h1);
        repeat (8) @(posedge clk);
        #1;
        chk(n_hit - c, 0);
        @(posedge clk);
        if (mode == 0)
        begin
            c = n_hit;
            ev_sel <= s;
            fire <= 1'b1;
            wait_hi(break_hit, 10, n);
            wait_hi(halted, 70000, n);
            chk(n, d + 1);
            chk(n_hit - c, 1);
            @(posedge clk);
            fire <= 1'b0;
        end
        else
        begin
            {force_halt, exc_break} <= mode == 1 ? 2'b10 : 2'b01;
            wait_hi(halted, 8, n);
        end
        repeat (8) @(posedge clk);
        #1;
        c = trace_count;
        chk(c, n_run);
        chk(c, model_q.size());
        for (i = 0; i < 10; i++)
        begin
            @(posedge clk);
            rd_offset <= i == 9 ? c - 1 : i;
            @(posedge clk);
            #1;
            chk(rd_record, model_q[c - 1 - (i == 9 ? c - 1 : i)]);
        end
        chk(trace_count, c);
        @(posedge clk);
        force_halt <= 1'b0;
        exc_break <= 1'b0;
    endtask
    initial
    begin
        {rst, run_start, force_halt, exc_break, trace_cond_set, fire} = 6'h20;
        ce = 1'b1;
        {or_enable, break_delay, ev_sel, rd_offset} = 58'h0;
        {error_cnt, n_tests, n_run, n_hit} = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        i = $urandom(32);
        run(0, 0);
        run(0, 1);
        run(1, 5);
        run(0, $urandom % 40 + 2);
        run(2, 3);
        run(0, 65535);
        i = trace_count;
        ce <= 1'b0;
        run_start <= 1'b1;
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        run_start <= 1'b0;
        #1;
        chk({running, halted}, 2'b01);
        chk(trace_count, i);
        final_report();
    end
endmodule
